//--- pkg/i2c_flags_pkg.sv
// Purpose: Constants for the I2C interrupt cause and status flag block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: Bit positions follow the cause register layout
package i2c_flags_pkg;
    // ==========================================================
    // Register map
    localparam logic [11:0] CAUSE_ADDR = 12'hF51;
    localparam logic [11:0] CTRL_ADDR = 12'hF52;
    localparam logic [11:0] IRQ_STAT_ADDR = 12'hF53;
    localparam logic [11:0] IRQ_EN_ADDR = 12'hF54;
    localparam logic [11:0] IRQ_CLR_ADDR = 12'hF55;
    localparam logic [11:0] OWN_ADDR_ADDR = 12'hF56;
    localparam logic [11:0] OWN_ADDR_HI_ADDR = 12'hF57;
    // ==========================================================
    // Cause register bits
    localparam int TXE_BIT = 7;
    localparam int RXF_BIT = 6;
    localparam int ADM_BIT = 5;
    localparam int GCS_BIT = 4;
    localparam int RD_BIT = 3;
    localparam int ARB_BIT = 2;
    localparam int STP_BIT = 1;
    localparam int NCK_BIT = 0;
    localparam logic [7:0] CAUSE_RESET = 8'h80;
    // Control register bits
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_GC_EN_BIT = 1;
    localparam int CTL_A10_BIT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
    // Interrupt-capable cause bits (general call and direction excluded)
    localparam logic [7:0] IRQ_CAUSE_MASK = 8'hE7;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    // Address phase states
    typedef enum logic [2:0] {
        ADR_IDLE = 3'h1,
        ADR_SECOND = 3'h2,
        ADR_DONE = 3'h4
    } adr_state_e;
endpackage

//--- src/i2c_addr_match.sv
// Purpose: Slave address comparison for one address byte
// Assumes: Byte as received, direction bit in bit 0
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none
module i2c_addr_match (
    // Received byte and setup
    input wire logic [7:0] addr_byte,
    input wire logic [6:0] own_addr,
    input wire logic gc_enable,
    // Results
    output logic own_hit,
    output logic gc_hit,
    output logic ten_prefix
);
    always_comb begin
        own_hit = (addr_byte[7:1] == own_addr);
        // General call (dir 0) and start byte (dir 1) share address zero
        gc_hit = gc_enable && (addr_byte[7:1] == i2c_flags_pkg::GEN_CALL_ADDR);
        ten_prefix = (addr_byte[7:3] == i2c_flags_pkg::TEN_BIT_PREFIX);
    end
endmodule
`default_nettype wire

//--- src/i2c_irq_ctrl.sv
// Purpose: Sticky interrupt status, enable and clear for cause events
// Assumes: Events are one-cycle pulses
// Notes: Set wins over a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module i2c_irq_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Events and software
    input wire logic [7:0] event_pulse,
    input wire logic en_we,
    input wire logic clr_we,
    input wire logic [7:0] wdata,
    // State
    output logic [7:0] status_q,
    output logic [7:0] enable_q,
    output logic irq
);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= i2c_flags_pkg::IRQ_RESET;
        end else begin
            status_q <= (status_q & ~(clr_we ? wdata : 8'h00)) | event_pulse;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= i2c_flags_pkg::IRQ_RESET;
        end else if (en_we) begin
            enable_q <= wdata;
        end
    end

    assign irq = |(status_q & enable_q);
endmodule
`default_nettype wire

//--- src/i2c_status_flags.sv
// Purpose: Interrupt cause and status flags of an I2C controller
// Assumes: Shifter and bus timing supply one-cycle event pulses
// Notes: Cause register is read only; reading it clears address match
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module i2c_status_flags (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // Controller events
    input wire logic data_reg_write,
    input wire logic data_reg_read,
    input wire logic data_reg_empty,
    input wire logic rx_byte_done,
    input wire logic rx_shifting,
    input wire logic addr_shifting,
    input wire logic slave_mode,
    input wire logic addr_byte_valid,
    input wire logic [7:0] addr_byte,
    input wire logic start_seen,
    input wire logic arb_lost,
    input wire logic stop_restart,
    input wire logic no_ack,
    // Interrupt
    output logic i2c_irq,
    output logic controller_irq
);
    // ==========================================================
    // Registers
    logic [7:0] ctrl_q;
    logic [9:0] own_addr_q;
    logic txe_q;
    logic rxf_q;
    logic adm_q;
    logic gcs_q;
    logic rd_q;
    logic arb_q;
    logic stp_q;
    logic nck_q;
    logic [7:0] rdata_q;
    i2c_flags_pkg::adr_state_e adr_q;
    logic first_hit_q;
    logic [7:0] cause;
    logic own_hit;
    logic gc_hit;
    logic ten_prefix;
    logic enable;
    logic gc_en;
    logic ten_bit;
    logic cause_read;
    logic first_addr;
    logic second_addr;
    logic adm_set;
    logic txe_rise;
    logic rxf_rise;
    logic adm_rise;
    logic [7:0] irq_stat;
    logic [7:0] irq_en;

    assign enable = ctrl_q[i2c_flags_pkg::CTL_EN_BIT];
    assign gc_en = ctrl_q[i2c_flags_pkg::CTL_GC_EN_BIT];
    assign ten_bit = ctrl_q[i2c_flags_pkg::CTL_A10_BIT];
    assign cause_read = reg_re && (reg_addr == i2c_flags_pkg::CAUSE_ADDR);
    assign first_addr = addr_byte_valid && (adr_q == i2c_flags_pkg::ADR_IDLE);
    assign second_addr = addr_byte_valid && (adr_q == i2c_flags_pkg::ADR_SECOND);

    i2c_addr_match u_match (
        .addr_byte(addr_byte),
        .own_addr(own_addr_q[6:0]),
        .gc_enable(gc_en),
        .own_hit(own_hit),
        .gc_hit(gc_hit),
        .ten_prefix(ten_prefix)
    );

    // ==========================================================
    // Software setup registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= i2c_flags_pkg::CTRL_RESET;
        end else if (reg_we && reg_addr == i2c_flags_pkg::CTRL_ADDR) begin
            ctrl_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            own_addr_q <= {2'h0, i2c_flags_pkg::OWN_ADDR_RESET};
        end else if (reg_we && reg_addr == i2c_flags_pkg::OWN_ADDR_ADDR) begin
            own_addr_q[7:0] <= reg_wdata;
        end else if (reg_we && reg_addr == i2c_flags_pkg::OWN_ADDR_HI_ADDR) begin
            own_addr_q[9:8] <= reg_wdata[1:0];
        end
    end

    // ==========================================================
    // Address phase tracking
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            adr_q <= i2c_flags_pkg::ADR_IDLE;
            first_hit_q <= 1'b0;
        end else if (!enable || start_seen) begin
            adr_q <= i2c_flags_pkg::ADR_IDLE;
            first_hit_q <= 1'b0;
        end else begin
            case (adr_q)
                i2c_flags_pkg::ADR_IDLE: begin
                    if (addr_byte_valid) begin
                        // 10-bit slave: prefix plus upper bits must match first
                        if (ten_bit && slave_mode && ten_prefix && !gc_hit) begin
                            adr_q <= i2c_flags_pkg::ADR_SECOND;
                            first_hit_q <= (addr_byte[2:1] == own_addr_q[9:8]);
                        end else begin
                            adr_q <= i2c_flags_pkg::ADR_DONE;
                        end
                    end
                end
                i2c_flags_pkg::ADR_SECOND: begin
                    if (addr_byte_valid) begin
                        adr_q <= i2c_flags_pkg::ADR_DONE;
                    end
                end
                i2c_flags_pkg::ADR_DONE: begin
                    adr_q <= i2c_flags_pkg::ADR_DONE;
                end
                default: begin
                    adr_q <= i2c_flags_pkg::ADR_IDLE;
                end
            endcase
        end
    end

    // 7-bit: own or enabled general call; 10-bit: enabled general call or both bytes
    always_comb begin
        adm_set = 1'b0;
        if (enable && slave_mode) begin
            if (first_addr && (gc_hit || (!ten_bit && own_hit))) begin
                adm_set = 1'b1;
            end else if (second_addr && first_hit_q && addr_byte == own_addr_q[7:0]) begin
                adm_set = 1'b1;
            end
        end
    end

    // ==========================================================
    // Cause flags
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            txe_q <= i2c_flags_pkg::CAUSE_RESET[i2c_flags_pkg::TXE_BIT];
        end else if (data_reg_write) begin
            txe_q <= 1'b0;
        end else begin
            txe_q <= enable && data_reg_empty;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rxf_q <= 1'b0;
        end else if (enable && rx_byte_done) begin
            rxf_q <= 1'b1;
        end else if (data_reg_read) begin
            rxf_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            adm_q <= 1'b0;
        end else if (adm_set) begin
            adm_q <= 1'b1;
        end else if (cause_read || !enable) begin
            adm_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gcs_q <= 1'b0;
        end else if (!enable) begin
            gcs_q <= 1'b0;
        end else if (first_addr && slave_mode) begin
            gcs_q <= gc_hit;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= 1'b0;
        end else if (!enable) begin
            rd_q <= 1'b0;
        end else if (first_addr) begin
            rd_q <= addr_byte[0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            arb_q <= 1'b0;
            stp_q <= 1'b0;
            nck_q <= 1'b0;
        end else begin
            arb_q <= enable && (arb_lost || (arb_q && !cause_read));
            stp_q <= enable && (stop_restart || (stp_q && !cause_read));
            nck_q <= enable && (no_ack || (nck_q && !cause_read));
        end
    end

    assign cause = {txe_q, rxf_q, adm_q, gcs_q, rd_q, arb_q, stp_q, nck_q};

    // Controller interrupt from cause bits that may request one
    always_comb begin
        controller_irq = |(cause & i2c_flags_pkg::IRQ_CAUSE_MASK);
        if (txe_q && (rx_shifting || (addr_shifting && rd_q))) begin
            controller_irq = |(cause & i2c_flags_pkg::IRQ_CAUSE_MASK & 8'h7F);
        end
    end

    // ==========================================================
    // Sticky status of rising flag events
    logic txe_d1_q;
    logic rxf_d1_q;
    logic adm_d1_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            txe_d1_q <= 1'b1;
            rxf_d1_q <= 1'b0;
            adm_d1_q <= 1'b0;
        end else begin
            txe_d1_q <= txe_q;
            rxf_d1_q <= rxf_q;
            adm_d1_q <= adm_q;
        end
    end
    assign txe_rise = txe_q && !txe_d1_q;
    assign rxf_rise = rxf_q && !rxf_d1_q;
    assign adm_rise = adm_q && !adm_d1_q;

    i2c_irq_ctrl u_irq (
        .core_clk(core_clk),
        .resetn(resetn),
        .event_pulse({txe_rise, rxf_rise, adm_rise, 2'h0,
                      enable && arb_lost, enable && stop_restart, enable && no_ack}),
        .en_we(reg_we && reg_addr == i2c_flags_pkg::IRQ_EN_ADDR),
        .clr_we(reg_we && reg_addr == i2c_flags_pkg::IRQ_CLR_ADDR),
        .wdata(reg_wdata & i2c_flags_pkg::IRQ_CAUSE_MASK),
        .status_q(irq_stat),
        .enable_q(irq_en),
        .irq(i2c_irq)
    );

    // ==========================================================
    // Read data, one cycle after the strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (reg_re) begin
            if (reg_addr == i2c_flags_pkg::CAUSE_ADDR) begin
                rdata_q <= cause;
            end else if (reg_addr == i2c_flags_pkg::CTRL_ADDR) begin
                rdata_q <= ctrl_q;
            end else if (reg_addr == i2c_flags_pkg::IRQ_STAT_ADDR) begin
                rdata_q <= irq_stat;
            end else if (reg_addr == i2c_flags_pkg::IRQ_EN_ADDR) begin
                rdata_q <= irq_en;
            end else if (reg_addr == i2c_flags_pkg::OWN_ADDR_ADDR) begin
                rdata_q <= own_addr_q[7:0];
            end else if (reg_addr == i2c_flags_pkg::OWN_ADDR_HI_ADDR) begin
                rdata_q <= {6'h00, own_addr_q[9:8]};
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

//--- dv/i2c_status_flags_asserts.sv
// Purpose: Port-level checks of the I2C cause and status flags
// Assumes: Control, enable and own address only change through register writes
// Notes: Helper logic shadows control state and the first address byte
`timescale 1ns/1ns
`default_nettype none
module i2c_status_flags_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    // Controller events
    input wire logic data_reg_write,
    input wire logic data_reg_empty,
    input wire logic rx_byte_done,
    input wire logic rx_shifting,
    input wire logic addr_shifting,
    input wire logic slave_mode,
    input wire logic addr_byte_valid,
    input wire logic [7:0] addr_byte,
    input wire logic start_seen,
    input wire logic arb_lost,
    input wire logic stop_restart,
    input wire logic no_ack,
    // Interrupts
    input wire logic i2c_irq,
    input wire logic controller_irq
);
    logic [7:0] ctl_q;
    logic [7:0] irq_en_q;
    logic [1:0] off_q;
    logic first_q;
    logic known_q;
    logic dir_q;
    logic gcall_q;
    wire cause_rd = reg_re && reg_addr == i2c_flags_pkg::CAUSE_ADDR;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // Shadow state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= 8'h00;
            irq_en_q <= 8'h00;
            off_q <= 2'h0;
        end else begin
            if (reg_we && reg_addr == i2c_flags_pkg::CTRL_ADDR) begin
                ctl_q <= reg_wdata;
            end
            if (reg_we && reg_addr == i2c_flags_pkg::IRQ_EN_ADDR) begin
                irq_en_q <= reg_wdata;
            end
            // Saturates so a long disable never wraps
            off_q <= ctl_q[0] ? 2'h0 : (off_q == 2'h2 ? off_q : off_q + 2'h1);
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            first_q <= 1'b0;
            known_q <= 1'b0;
            dir_q <= 1'b0;
            gcall_q <= 1'b0;
        end else if (!ctl_q[0]) begin
            first_q <= start_seen;
            known_q <= 1'b0;
            gcall_q <= 1'b0;
        end else if (start_seen) begin
            first_q <= 1'b1;
        end else if (addr_byte_valid) begin
            first_q <= 1'b0;
            if (first_q) begin
                known_q <= 1'b1;
                dir_q <= addr_byte[0];
                if (slave_mode) begin
                    gcall_q <= ctl_q[1] && addr_byte[7:1] == 7'h00;
                end
            end
        end
    end
    // ==========================================
    // Properties
    property p_ev_irq;
        ctl_q[0] && !reg_we && (arb_lost || stop_restart || no_ack) |=> controller_irq;
    endproperty
    a_ev_irq: assert property (p_ev_irq) else $error("event gave no irq");
    property p_irq_mask;
        i2c_irq |-> (irq_en_q & i2c_flags_pkg::IRQ_CAUSE_MASK) != 8'h00;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq without enable");
    property p_tx_irq;
        ctl_q[0] && data_reg_empty && !data_reg_write && !reg_we
            |=> controller_irq || rx_shifting || addr_shifting;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("empty gave no irq");
    property p_rx_irq;
        ctl_q[0] && rx_byte_done && !reg_we |=> controller_irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx byte gave no irq");
    property p_gc_hit;
        ctl_q[2:0] == 3'h3 && slave_mode && first_q && addr_byte_valid
            && addr_byte == 8'h00 && !reg_we |=> controller_irq;
    endproperty
    a_gc_hit: assert property (p_gc_hit) else $error("general call no irq");
    property p_dis_clr;
        cause_rd && off_q != 2'h0 |=> reg_rdata[4:3] == 2'b00;
    endproperty
    a_dis_clr: assert property (p_dis_clr) else $error("flags kept while off");
    property p_dir_gc;
        cause_rd && known_q && ctl_q[0] && !reg_we && !addr_byte_valid && !start_seen
            |=> reg_rdata[4:3] == {gcall_q, dir_q};
    endproperty
    a_dir_gc: assert property (p_dir_gc) else $error("direction flags wrong");
    property p_rd_idle;
        !$past(reg_re) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule
`default_nettype wire

//--- dv/i2c_bus_agent.sv
// Purpose: Far-side bus traffic as seen by the flag block
// Assumes: Address and data bytes take eight shift cycles
// Notes: Address byte is scrambled after its pulse, never held
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_agent (
    // Clock
    input wire logic core_clk,
    // Bus events
    output logic start_seen,
    output logic addr_shifting,
    output logic addr_byte_valid,
    output logic [7:0] addr_byte,
    output logic rx_shifting,
    output logic rx_byte_done
);
    initial begin
        start_seen = 1'b0;
        addr_shifting = 1'b0;
        addr_byte_valid = 1'b0;
        addr_byte = 8'h00;
        rx_shifting = 1'b0;
        rx_byte_done = 1'b0;
    end
    task automatic addr_phase(input logic [7:0] b, input logic restart);
        @(posedge core_clk);
        start_seen <= restart;
        @(posedge core_clk);
        start_seen <= 1'b0;
        addr_shifting <= 1'b1;
        repeat (8) @(posedge core_clk);
        addr_shifting <= 1'b0;
        addr_byte_valid <= 1'b1;
        addr_byte <= b;
        @(posedge core_clk);
        addr_byte_valid <= 1'b0;
        addr_byte <= ~b;
    endtask
    task automatic recv();
        @(posedge core_clk);
        rx_shifting <= 1'b1;
        repeat (8) @(posedge core_clk);
        rx_shifting <= 1'b0;
        rx_byte_done <= 1'b1;
        @(posedge core_clk);
        rx_byte_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- dv/i2c_status_flags_tb.sv
// Purpose: Self-checking bench for the I2C cause and status flags
// Assumes: Register reads answer one cycle later
// Notes: Reads queue masked expectations; a monitor compares them
`timescale 1ns/1ns
`default_nettype none
module i2c_status_flags_tb;
    logic core_clk, resetn, reg_we, reg_re, data_reg_write, data_reg_read;
    logic data_reg_empty, slave_mode, arb_lost, stop_restart, no_ack;
    logic start_seen, addr_shifting, addr_byte_valid, rx_shifting, rx_byte_done;
    logic i2c_irq, controller_irq;
    logic rd_pend = 1'b0;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, addr_byte, b;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    int miscompares = 0;
    int checks_done = 0;
    i2c_status_flags DUT (.*);
    i2c_bus_agent u_bus (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ==========================================
    // Tasks
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge core_clk);
        reg_re <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] e, input logic [7:0] m);
        rd(i2c_flags_pkg::CAUSE_ADDR, e, m);
    endtask
    task automatic evt(input logic [4:0] v);
        @(posedge core_clk);
        {data_reg_write, data_reg_read, arb_lost, stop_restart, no_ack} <= v;
        @(posedge core_clk);
        {data_reg_write, data_reg_read, arb_lost, stop_restart, no_ack} <= 5'h00;
    endtask
    task automatic irqs(input logic [1:0] e);
        @(negedge core_clk);
        cmp({6'h00, i2c_irq, controller_irq}, {6'h00, e});
        // Back on a rising edge so following stimulus stays edge aligned
        @(posedge core_clk);
    endtask
    task automatic adr(input logic [7:0] c, input logic s, input logic [7:0] a,
                       input logic [7:0] e, input logic [7:0] m);
        wr(i2c_flags_pkg::CTRL_ADDR, 8'h00);
        wr(i2c_flags_pkg::CTRL_ADDR, c);
        slave_mode <= s;
        u_bus.addr_phase(a, 1'b1);
        rc(e, m);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================
    // Monitor and watchdog
    always @(posedge core_clk) rd_pend <= reg_re;
    always @(negedge core_clk) begin
        if (rd_pend) begin
            cmp(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        {reg_we, reg_re, reg_addr, reg_wdata} = '0;
        {data_reg_write, data_reg_read, arb_lost, stop_restart, no_ack} = 5'h00;
        data_reg_empty = 1'b1;
        slave_mode = 1'b0;
        void'($urandom(32'h091D19EC));
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd(i2c_flags_pkg::CTRL_ADDR, i2c_flags_pkg::CTRL_RESET, 8'hFF);
        rd(i2c_flags_pkg::IRQ_EN_ADDR, i2c_flags_pkg::IRQ_RESET, 8'hFF);
        rc(8'h00, 8'hD8);
        $display("test reset done");
        wr(i2c_flags_pkg::CTRL_ADDR, 8'h01);
        rc(8'h80, 8'hFF);
        irqs(2'b01);
        data_reg_empty <= 1'b0;
        evt(5'h10);
        rc(8'h00, 8'hFF);
        u_bus.recv();
        rc(8'h40, 8'hFF);
        rc(8'h40, 8'hFF);
        evt(5'h08);
        rc(8'h00, 8'hFF);
        $display("test data flags done");
        for (int i = 0; i < 3; i++) begin
            evt(5'h04 >> i);
            rc(8'h04 >> i, 8'hFF);
            rc(8'h00, 8'hFF);
        end
        $display("test events done");
        wr(i2c_flags_pkg::OWN_ADDR_ADDR, 8'h2A);
        wr(i2c_flags_pkg::OWN_ADDR_HI_ADDR, 8'h02);
        adr(8'h03, 1'b1, 8'h00, 8'h30, 8'hFF);
        wr(i2c_flags_pkg::CTRL_ADDR, 8'h00);
        rc(8'h00, 8'hFF);
        adr(8'h03, 1'b1, 8'h01, 8'h38, 8'hFF);
        adr(8'h01, 1'b1, 8'h00, 8'h00, 8'hFF);
        adr(8'h01, 1'b1, 8'h55, 8'h28, 8'hFF);
        b = 8'($urandom);
        adr(8'h01, 1'b0, b, {4'h0, b[0], 3'h0}, 8'hFF);
        adr(8'h05, 1'b1, 8'hF4, 8'h00, 8'h20);
        u_bus.addr_phase(8'h2A, 1'b0);
        rc(8'h20, 8'h20);
        $display("test address done");
        wr(i2c_flags_pkg::IRQ_CLR_ADDR, 8'hFF);
        evt(5'h04);
        irqs(2'b01);
        rd(i2c_flags_pkg::IRQ_STAT_ADDR, 8'h04, 8'hFF);
        wr(i2c_flags_pkg::IRQ_EN_ADDR, 8'h04);
        irqs(2'b11);
        wr(i2c_flags_pkg::IRQ_CLR_ADDR, 8'h04);
        irqs(2'b01);
        rd(i2c_flags_pkg::IRQ_STAT_ADDR, 8'h00, 8'hFF);
        rd(12'hF5A, 8'h00, 8'hFF);
        wr(i2c_flags_pkg::CAUSE_ADDR, 8'($urandom));
        rc(8'h04, 8'hFF);
        irqs(2'b00);
        data_reg_empty <= 1'b1;
        fork
            u_bus.recv();
            begin
                repeat (4) @(posedge core_clk);
                irqs(2'b00);
            end
        join
        irqs(2'b01);
        rd(i2c_flags_pkg::IRQ_STAT_ADDR, 8'hC0, 8'hFF);
        $display("test interrupts done");
        repeat (2) @(posedge core_clk);
        if (exp_q.size() != 0) begin
            miscompares++;
        end
        end_of_test();
    end
endmodule
bind i2c_status_flags i2c_status_flags_asserts u_chk (.*);
`default_nettype wire
